// ===== phase_compare.sv
// Purpose: Phase comparison with antibacklash pulses and digital lock detection.
// Assumes: Inputs are one-cycle pulses on the system clock.
// Notes: Lock needs LOCK_COUNT consecutive comparisons with small phase error.
`default_nettype none

module phase_compare #(
  parameter int ANTIBACKLASH_CYCLES = synth_prog_pkg::ANTIBACKLASH_CYCLES,
  parameter int LOCK_WINDOW_CYCLES = synth_prog_pkg::LOCK_WINDOW_CYCLES,
  parameter int LOCK_COUNT = synth_prog_pkg::LOCK_COUNT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEnable,
  input wire synth_prog_pkg::compare_in_s edges,
  output logic upPulse,
  output logic downPulse,
  output logic locked
);

  if (ANTIBACKLASH_CYCLES < 1 || ANTIBACKLASH_CYCLES > 255)
  begin : gBadAbp
    $error("antibacklash cycle count out of range");
  end
  if (LOCK_COUNT < 1 || LOCK_COUNT > 65535 || LOCK_WINDOW_CYCLES > 254)
  begin : gBadLock
    $error("lock detector settings out of range");
  end

  localparam logic [7:0] ABP_LAST = 8'(ANTIBACKLASH_CYCLES - 1);
  localparam logic [7:0] WINDOW = 8'(LOCK_WINDOW_CYCLES);
  localparam logic [15:0] GOOD_LAST = 16'(LOCK_COUNT - 1);

  typedef struct packed {
    logic up;
    logic down;
    logic [7:0] overlapCnt;
    logic [7:0] errCnt;
    logic [15:0] goodCnt;
    logic locked;
  } pfd_state_s;

  pfd_state_s pfd_reg;
  pfd_state_s pfd_next;

  always_comb
  begin
    logic clear;
    clear = 1'b0;
    pfd_next = pfd_reg;
    if (clkEnable)
    begin
      if (pfd_reg.up && pfd_reg.down)
      begin
        if (pfd_reg.overlapCnt >= ABP_LAST)
        begin
          clear = 1'b1;
          pfd_next.overlapCnt = 8'h00;
        end
        else
        begin
          pfd_next.overlapCnt = pfd_reg.overlapCnt + 8'h01;
        end
      end
      // A new edge in the clearing cycle is kept, so no comparison is lost.
      pfd_next.up = (pfd_reg.up && !clear) || edges.refEdge;
      pfd_next.down = (pfd_reg.down && !clear) || edges.fbEdge;
      if ((pfd_reg.up ^ pfd_reg.down) && pfd_reg.errCnt != 8'hFF)
      begin
        pfd_next.errCnt = pfd_reg.errCnt + 8'h01;
      end
      if (clear)
      begin
        pfd_next.errCnt = 8'h00;
        if (pfd_reg.errCnt <= WINDOW)
        begin
          if (pfd_reg.goodCnt >= GOOD_LAST)
          begin
            pfd_next.locked = 1'b1;
          end
          else
          begin
            pfd_next.goodCnt = pfd_reg.goodCnt + 16'h0001;
          end
        end
        else
        begin
          pfd_next.goodCnt = 16'h0000;
          pfd_next.locked = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pfd_reg <= '0;
    end
    else
    begin
      pfd_reg <= pfd_next;
    end
  end

  assign upPulse = pfd_reg.up;
  assign downPulse = pfd_reg.down;
  assign locked = pfd_reg.locked;

endmodule // phase_compare

`default_nettype wire

// ===== serial_host_model.sv
// Purpose: Host model that shifts words in and pulses the load strobe.
// Assumes: Link clock period of 32 ns, phase unrelated to the system clock.
// Notes: The link clock stands still outside frames and while loading.
`default_nettype none

module serial_host_model (
  input wire logic sys_clk,
  output logic serialClk,
  output logic serialData,
  output logic loadLatchStrobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    serialClk = 1'b0;
    serialData = 1'b1;
    loadLatchStrobe = 1'b0;
  end

  task automatic send(input logic [31:0] word);
    #3;
    for (int i = 31; i >= 0; i--)
    begin
      serialData = word[i];
      #16 serialClk = 1'b1;
      #16 serialClk = 1'b0;
    end
    // The data line has no pull, so it is left at the inverse of the last bit.
    serialData = ~word[0];
    @(negedge sys_clk);
    loadLatchStrobe = 1'b1;
    repeat (6) @(negedge sys_clk);
    loadLatchStrobe = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule // serial_host_model

`default_nettype wire

// ===== serial_shift_in.sv
// Purpose: Serial word capture on the link clock.
// Assumes: The serial clock stands still while the load strobe is high.
// Notes: The word is read by the system domain only after the synchronised strobe rises.
`default_nettype none

module serial_shift_in (
  input wire logic serialClk,
  input wire logic serialData,
  output logic [synth_prog_pkg::WORD_W-1:0] shiftWord
);

  typedef struct packed {
    logic [synth_prog_pkg::WORD_W-1:0] word;
  } shift_state_s;

  shift_state_s shift_reg;
  shift_state_s shift_next;

  always_comb
  begin
    shift_next = shift_reg;
    shift_next.word = {shift_reg.word[synth_prog_pkg::WORD_W-2:0], serialData};
  end

  // Data only: the link clock may stop, so no reset is relied on here.
  always_ff @(posedge serialClk)
  begin
    shift_reg <= shift_next;
  end

  assign shiftWord = shift_reg.word;

endmodule // serial_shift_in

`default_nettype wire

// ===== synth_prog_asserts.sv
// Purpose: Port-level checks for the synthesizer programming block.
// Assumes: All checked outputs belong to the system clock domain.
// Notes: Latch outputs may only move while a load strobe is recent.
`default_nettype none

module synth_prog_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic loadLatchStrobe,
  input wire logic upPulse,
  input wire logic downPulse,
  input wire logic lockIndicator,
  input wire logic monitorOutputEnable,
  input wire logic [synth_prog_pkg::PWR_W-1:0] outputPowerLevel,
  input wire logic [synth_prog_pkg::CP_W-1:0] chargePumpCurrent,
  input wire logic chargePumpDisable,
  input wire logic [synth_prog_pkg::DIVSEL_W-1:0] outputDividerSelect,
  input wire logic integerMode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ******
  // Checks
  // ******
  a_up_ends_overlap: assert property ($fell(upPulse) |-> $past(downPulse))
    else $error("up pulse ended without down overlap");
  a_down_ends_overlap: assert property ($fell(downPulse) |-> $past(upPulse))
    else $error("down pulse ended without up overlap");
  a_power_after_load: assert property ($changed(outputPowerLevel) |-> $past(loadLatchStrobe, 2))
    else $error("power level moved without a load");
  a_cp_after_load: assert property ($changed(chargePumpCurrent) |-> $past(loadLatchStrobe, 2))
    else $error("charge pump current moved without a load");
  a_cpoff_after_load: assert property ($changed(chargePumpDisable) |-> $past(loadLatchStrobe, 2))
    else $error("charge pump disable moved without a load");
  a_divsel_after_load: assert property ($changed(outputDividerSelect) |-> $past(loadLatchStrobe, 2))
    else $error("divider select moved without a load");
  a_intmode_after_load: assert property ($changed(integerMode) |-> $past(loadLatchStrobe, 2))
    else $error("integer mode moved without a load");
  a_monen_after_load: assert property ($changed(monitorOutputEnable) |-> $past(loadLatchStrobe, 2))
    else $error("monitor enable moved without a load");

  cover property ($rose(lockIndicator));
  cover property ($fell(lockIndicator));
  cover property (upPulse && downPulse);
  cover property ($changed(outputDividerSelect));
endmodule // synth_prog_asserts

bind synth_serial_program_latches synth_prog_asserts chk_u (.sys_clk, .rst_n, .loadLatchStrobe,
  .upPulse, .downPulse, .lockIndicator, .monitorOutputEnable, .outputPowerLevel,
  .chargePumpCurrent, .chargePumpDisable, .outputDividerSelect, .integerMode);

`default_nettype wire

// ===== synth_prog_pkg.sv
// Purpose: Shared constants and carrier types for the synthesizer programming block.
// Assumes: 125 MHz system clock; 32-bit serial words with the target select in the low bits.
// Notes: Field positions are the bit positions inside one programmed word.
`default_nettype none

package synth_prog_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int WORD_W = 32;
  localparam int TARGET_W = 3;
  localparam int TARGET_LSB = 0;
  localparam int LATCH_COUNT = 6;
  localparam logic [2:0] TARGET_INT_NUMERATOR_VALUE = 3'h0;
  localparam logic [2:0] TARGET_PHASE_MOD = 3'h1;
  localparam logic [2:0] TARGET_REF_LOOP = 3'h2;
  localparam logic [2:0] TARGET_OUTPUT = 3'h4;

  // Latch 0.
  localparam int INT_LSB = 15;
  localparam int INT_W = 16;
  localparam int NUMERATOR_VALUE_LSB = 3;
  localparam int NUMERATOR_VALUE_W = 12;

  // Latch 1.
  localparam int PHASE_LSB = 15;
  localparam int PHASE_W = 12;
  localparam int MOD_LSB = 3;
  localparam int MOD_W = 12;

  // Latch 2.
  localparam int MON_LSB = 26;
  localparam int MON_W = 3;
  localparam int DOUBLER_BIT = 25;
  localparam int HALVE_BIT = 24;
  localparam int RCOUNT_LSB = 14;
  localparam int RCOUNT_W = 10;
  localparam int DBUF_BIT = 13;
  localparam int CP_LSB = 9;
  localparam int CP_W = 3;
  localparam int LDF_BIT = 8;
  localparam int PDOWN_BIT = 5;
  localparam int CP_OFF_BIT = 4;

  // Latch 4.
  localparam int DIVSEL_LSB = 20;
  localparam int DIVSEL_W = 3;
  localparam int MUTE_UNTIL_LOCK_BIT = 10;
  localparam int RFEN_BIT = 5;
  localparam int PWR_LSB = 3;
  localparam int PWR_W = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [WORD_W-1:0] LATCH_RESET = 32'h0000_0000;
  localparam logic [RCOUNT_W-1:0] RCOUNT_RESET = 10'h001;
  localparam logic [MOD_W-1:0] MOD_RESET = 12'h002;

  // ****************************************
  // Monitor select codes
  // ****************************************
  localparam logic [2:0] MON_OFF = 3'h0;
  localparam logic [2:0] MON_HIGH = 3'h1;
  localparam logic [2:0] MON_LOW = 3'h2;
  localparam logic [2:0] MON_REF_DIV = 3'h3;
  localparam logic [2:0] MON_FB_DIV = 3'h4;
  localparam logic [2:0] MON_LOCK = 3'h6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ANTIBACKLASH_PS = 4200;
  localparam int ANTIBACKLASH_CYCLES_RAW = (ANTIBACKLASH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ANTIBACKLASH_CYCLES = (ANTIBACKLASH_CYCLES_RAW < 1) ? 1 : ANTIBACKLASH_CYCLES_RAW;
  localparam int LOCK_WINDOW_CYCLES = 2;
  localparam int LOCK_COUNT = 16;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [MOD_W-1:0] modulus;
    logic doubler;
    logic halve;
    logic [RCOUNT_W-1:0] rcount;
    logic [CP_W-1:0] cpCurrent;
    logic [DIVSEL_W-1:0] divSel;
  } settings_s;

  typedef struct packed {
    logic refEdge;
    logic fbEdge;
  } compare_in_s;

endpackage

`default_nettype wire

// ===== synth_serial_program_latches.sv
// Purpose: Serial programming latches, dividers and output controls of a synthesizer.
// Assumes: Host stops the serial clock while the load strobe is high.
// Notes: Reference and feedback inputs are pins and pass two flip-flops first.
`default_nettype none

module synth_serial_program_latches #(
  parameter int LOCK_WINDOW_CYCLES = synth_prog_pkg::LOCK_WINDOW_CYCLES,
  parameter int LOCK_COUNT = synth_prog_pkg::LOCK_COUNT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEnable,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadLatchStrobe,
  input wire logic refIn,
  input wire logic fbIn,
  output logic upPulse,
  output logic downPulse,
  output logic lockIndicator,
  output logic monitorOutput,
  output logic monitorOutputEnable,
  output logic rfSupplyOn,
  output logic [synth_prog_pkg::PWR_W-1:0] outputPowerLevel,
  output logic [synth_prog_pkg::CP_W-1:0] chargePumpCurrent,
  output logic chargePumpDisable,
  output logic [synth_prog_pkg::DIVSEL_W-1:0] outputDividerSelect,
  output logic integerMode
);

  // ****************************************
  // Local types
  // ****************************************
  localparam int W = synth_prog_pkg::WORD_W;

  typedef struct packed {
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic [2:0] prevB;
    logic [synth_prog_pkg::LATCH_COUNT-1:0][W-1:0] latchWord;
    synth_prog_pkg::settings_s active;
    logic [10:0] refCount;
    logic [16:0] fbCount;
    logic [synth_prog_pkg::NUMERATOR_VALUE_W-1:0] fracAcc;
    logic fracCarry;
    logic refPulse;
    logic fbPulse;
    logic monOut;
    logic monEn;
    logic rfOn;
  } top_state_s;

  top_state_s top_reg;
  top_state_s top_next;
  logic [W-1:0] shiftWord;
  logic locked;
  synth_prog_pkg::compare_in_s edges;

  // ****************************************
  // Serial capture on the link clock
  // ****************************************
  serial_shift_in uShift (
    .serialClk(serialClk),
    .serialData(serialData),
    .shiftWord(shiftWord)
  );

  // ****************************************
  // Latches, dividers and outputs
  // ****************************************
  always_comb
  begin
    logic strobeRise;
    logic refEvent;
    logic fbRise;
    logic [2:0] target;
    logic [W-1:0] r1;
    logic [W-1:0] r2;
    logic [W-1:0] r4;
    logic [9:0] rcount;
    logic [10:0] refTerm;
    logic [16:0] fbTerm;
    logic [15:0] intValue;
    logic [11:0] fracValue;
    logic [12:0] fracSum;
    logic intMode;
    logic [2:0] monSel;
    strobeRise = 1'b0;
    refEvent = 1'b0;
    fbRise = 1'b0;
    target = 3'h0;
    r1 = top_reg.latchWord[1];
    r2 = top_reg.latchWord[2];
    r4 = top_reg.latchWord[4];
    rcount = top_reg.active.rcount;
    refTerm = 11'h001;
    fbTerm = 17'h0_0001;
    intValue = top_reg.latchWord[0][synth_prog_pkg::INT_LSB +: synth_prog_pkg::INT_W];
    fracValue = top_reg.latchWord[0][synth_prog_pkg::NUMERATOR_VALUE_LSB +: synth_prog_pkg::NUMERATOR_VALUE_W];
    fracSum = 13'h0000;
    intMode = 1'b0;
    monSel = r2[synth_prog_pkg::MON_LSB +: synth_prog_pkg::MON_W];
    top_next = top_reg;
    if (clkEnable)
    begin
      // Bit 0 strobe, bit 1 feedback, bit 2 reference; first stage feeds only the second.
      top_next.syncA = {refIn, fbIn, loadLatchStrobe};
      top_next.syncB = top_reg.syncA;
      top_next.prevB = top_reg.syncB;
      strobeRise = top_reg.syncB[0] && !top_reg.prevB[0];
      fbRise = top_reg.syncB[1] && !top_reg.prevB[1];
      // A doubled reference counts both edges of the input.
      refEvent = top_reg.active.doubler ? (top_reg.syncB[2] ^ top_reg.prevB[2])
                                        : (top_reg.syncB[2] && !top_reg.prevB[2]);

      if (strobeRise)
      begin
        target = shiftWord[synth_prog_pkg::TARGET_LSB +: synth_prog_pkg::TARGET_W];
        if (target < 3'(synth_prog_pkg::LATCH_COUNT))
        begin
          top_next.latchWord[target] = shiftWord;
        end
        if (target == synth_prog_pkg::TARGET_INT_NUMERATOR_VALUE)
        begin
          top_next.active.phase = r1[synth_prog_pkg::PHASE_LSB +: synth_prog_pkg::PHASE_W];
          top_next.active.modulus = r1[synth_prog_pkg::MOD_LSB +: synth_prog_pkg::MOD_W];
          top_next.active.doubler = r2[synth_prog_pkg::DOUBLER_BIT];
          top_next.active.halve = r2[synth_prog_pkg::HALVE_BIT];
          top_next.active.rcount = r2[synth_prog_pkg::RCOUNT_LSB +: synth_prog_pkg::RCOUNT_W];
          top_next.active.cpCurrent = r2[synth_prog_pkg::CP_LSB +: synth_prog_pkg::CP_W];
          if (r2[synth_prog_pkg::DBUF_BIT])
          begin
            top_next.active.divSel = r4[synth_prog_pkg::DIVSEL_LSB +: synth_prog_pkg::DIVSEL_W];
          end
        end
        if (target == synth_prog_pkg::TARGET_OUTPUT && !r2[synth_prog_pkg::DBUF_BIT])
        begin
          top_next.active.divSel =
            shiftWord[synth_prog_pkg::DIVSEL_LSB +: synth_prog_pkg::DIVSEL_W];
        end
      end

      if (rcount == 10'h000)
      begin
        rcount = 10'h001;
      end
      refTerm = top_reg.active.halve ? {rcount, 1'b0} : {1'b0, rcount};
      top_next.refPulse = 1'b0;
      if (refEvent)
      begin
        if (top_reg.refCount >= refTerm - 11'h001)
        begin
          top_next.refCount = 11'h000;
          top_next.refPulse = 1'b1;
        end
        else
        begin
          top_next.refCount = top_reg.refCount + 11'h001;
        end
      end

      intMode = (fracValue == 12'h000) && r2[synth_prog_pkg::LDF_BIT];
      // integer and fraction feed the divider
      fbTerm = {1'b0, intValue} + {16'h0000, top_reg.fracCarry && !intMode};
      if (fbTerm == 17'h0_0000)
      begin
        fbTerm = 17'h0_0001;
      end
      top_next.fbPulse = 1'b0;
      if (fbRise)
      begin
        if (top_reg.fbCount >= fbTerm - 17'h0_0001)
        begin
          top_next.fbCount = 17'h0_0000;
          top_next.fbPulse = 1'b1;
          fracSum = {1'b0, top_reg.fracAcc} + {1'b0, fracValue};
          if (intMode)
          begin
            top_next.fracAcc = '0;
            top_next.fracCarry = 1'b0;
          end
          else if (fracSum >= {1'b0, top_reg.active.modulus})
          begin
            top_next.fracAcc = 12'(fracSum - {1'b0, top_reg.active.modulus});
            top_next.fracCarry = 1'b1;
          end
          else
          begin
            top_next.fracAcc = fracSum[11:0];
            top_next.fracCarry = 1'b0;
          end
        end
        else
        begin
          top_next.fbCount = top_reg.fbCount + 17'h0_0001;
        end
      end

      top_next.monEn = 1'b1;
      case (monSel)
        synth_prog_pkg::MON_HIGH: top_next.monOut = 1'b1;
        synth_prog_pkg::MON_REF_DIV: top_next.monOut = top_reg.refPulse;
        synth_prog_pkg::MON_FB_DIV: top_next.monOut = top_reg.fbPulse;
        synth_prog_pkg::MON_LOCK: top_next.monOut = locked;
        synth_prog_pkg::MON_OFF:
        begin
          top_next.monOut = 1'b0;
          top_next.monEn = 1'b0;
        end
        default: top_next.monOut = 1'b0;
      endcase

      top_next.rfOn = r4[synth_prog_pkg::RFEN_BIT] && !r2[synth_prog_pkg::PDOWN_BIT] &&
                      (!r4[synth_prog_pkg::MUTE_UNTIL_LOCK_BIT] || locked);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      top_reg <= '0;
      top_reg.active.rcount <= synth_prog_pkg::RCOUNT_RESET;
      top_reg.active.modulus <= synth_prog_pkg::MOD_RESET;
    end
    else
    begin
      top_reg <= top_next;
    end
  end

  // ****************************************
  // Phase comparison
  // ****************************************
  assign edges.refEdge = top_reg.refPulse;
  assign edges.fbEdge = top_reg.fbPulse;

  phase_compare #(
    .ANTIBACKLASH_CYCLES(synth_prog_pkg::ANTIBACKLASH_CYCLES),
    .LOCK_WINDOW_CYCLES(LOCK_WINDOW_CYCLES),
    .LOCK_COUNT(LOCK_COUNT)
  ) uCompare (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEnable(clkEnable),
    .edges(edges),
    .upPulse(upPulse),
    .downPulse(downPulse),
    .locked(locked)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // lock indicator follows detector
  assign lockIndicator = locked;
  assign monitorOutput = top_reg.monOut;
  assign monitorOutputEnable = top_reg.monEn;
  assign rfSupplyOn = top_reg.rfOn;
  assign outputPowerLevel =
    top_reg.latchWord[4][synth_prog_pkg::PWR_LSB +: synth_prog_pkg::PWR_W];
  assign chargePumpCurrent = top_reg.active.cpCurrent;
  assign chargePumpDisable = top_reg.latchWord[2][synth_prog_pkg::CP_OFF_BIT] ||
                             top_reg.latchWord[2][synth_prog_pkg::PDOWN_BIT];
  assign outputDividerSelect = top_reg.active.divSel;
  assign integerMode = (top_reg.latchWord[0][synth_prog_pkg::NUMERATOR_VALUE_LSB +: synth_prog_pkg::NUMERATOR_VALUE_W]
                        == 12'h000) && top_reg.latchWord[2][synth_prog_pkg::LDF_BIT];

endmodule // synth_serial_program_latches

`default_nettype wire

// ===== synth_serial_program_latches_test.sv
// Purpose: Self-checking bench with a latch model for the programming block.
// Assumes: Lock count shortened to 2; clock enable held high throughout.
// Notes: Reference and feedback pins share one waveform so ratios decide lock.
`default_nettype none

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end

module synth_serial_program_latches_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic refIn = 1'b0;
  logic fbIn = 1'b0;
  logic pllRun = 1'b0;
  logic [1:0] phase = 2'h0;
  logic serialClk, serialData, loadLatchStrobe, upPulse, downPulse, lockIndicator;
  logic monitorOutput, monitorOutputEnable, rfSupplyOn, chargePumpDisable, integerMode;
  logic [1:0] outputPowerLevel;
  logic [2:0] chargePumpCurrent, outputDividerSelect;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] lat [6];
  logic [2:0] actCp = 3'h0;
  logic [2:0] actDiv = 3'h0;
  logic expLock = 1'b0;

  always #4 sys_clk = ~sys_clk;

  always @(negedge sys_clk)
  begin
    if (pllRun)
    begin
      phase <= phase + 2'h1;
      refIn <= phase[1];
      fbIn <= phase[1];
    end
  end

  serial_host_model host_u (.sys_clk(sys_clk), .serialClk(serialClk),
    .serialData(serialData), .loadLatchStrobe(loadLatchStrobe));

  synth_serial_program_latches #(.LOCK_COUNT(2)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEnable(1'b1), .serialClk(serialClk), .serialData(serialData),
    .loadLatchStrobe(loadLatchStrobe), .refIn(refIn), .fbIn(fbIn), .upPulse(upPulse),
    .downPulse(downPulse), .lockIndicator(lockIndicator), .monitorOutput(monitorOutput),
    .monitorOutputEnable(monitorOutputEnable), .rfSupplyOn(rfSupplyOn),
    .outputPowerLevel(outputPowerLevel), .chargePumpCurrent(chargePumpCurrent),
    .chargePumpDisable(chargePumpDisable), .outputDividerSelect(outputDividerSelect),
    .integerMode(integerMode));

  // ******
  // Model
  // ******
  function automatic logic [31:0] w0(input logic [15:0] n, input logic [11:0] f);
    return {1'b0, n, f, 3'h0};
  endfunction

  // reserved bits fixed
  // Bit 6 is the reserved one that must be written high.
  function automatic logic [31:0] w2(input logic [2:0] m, input logic [9:0] r,
    input logic db, input logic [2:0] cp, input logic lock_detect_function, input logic pd, input logic off);
    return {3'h0, m, 2'h0, r, db, 1'b0, cp, lock_detect_function, 2'h1, pd, off, 1'b0, 3'h2};
  endfunction

  function automatic logic [31:0] w4(input logic [2:0] d, input logic mt, input logic en,
    input logic [1:0] p);
    return {9'h0, d, 9'h0, mt, 4'h0, en, p, 3'h4};
  endfunction

  task automatic check();
    logic [2:0] m;
    m = lat[2][28:26];
    `CHK("power", lat[4][4:3], outputPowerLevel)
    `CHK("cpCurrent", actCp, chargePumpCurrent)
    `CHK("cpDisable", lat[2][4] | lat[2][5], chargePumpDisable)
    `CHK("divSel", actDiv, outputDividerSelect)
    `CHK("intMode", lat[0][14:3] == 12'h000 && lat[2][8], integerMode)
    `CHK("monEn", m != 3'h0, monitorOutputEnable)
    // With the pins idle the divider taps must read low as well.
    if (m != 3'h0 && (!pllRun || (m != 3'h3 && m != 3'h4)))
      `CHK("monitor", m == 3'h1 || (m == 3'h6 && expLock), monitorOutput)
    `CHK("rfSupply", lat[4][5] & ~lat[2][5] & (~lat[4][10] | expLock), rfSupplyOn)
    `CHK("lock", expLock, lockIndicator)
  endtask

  task automatic wr(input logic [31:0] w);
    host_u.send(w);
    if (w[2:0] == 3'h0)
    begin
      actCp = lat[2][11:9];
      if (lat[2][13])
        actDiv = lat[4][22:20];
    end
    if (w[2:0] == 3'h4 && !lat[2][13])
      actDiv = w[22:20];
    if (w[2:0] < 3'h6)
      lat[w[2:0]] = w;
    check();
  endtask

  task automatic waitLock(input logic want);
    int n;
    n = 0;
    while (lockIndicator !== want && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    expLock = want;
    // Supply and monitor register the lock a cycle after the indicator moves.
    repeat (2) @(negedge sys_clk);
    check();
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("watchdog expired");
    conclude();
  end

  // ******
  // Tests
  // ******
  initial
  begin
    lat = '{default: 32'h0};
    void'($urandom(32'hb65a51fe));
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    check();
    $display("test reset done");
    for (int p = 0; p < 4; p++)
      wr(w4(3'($urandom), 1'b0, 1'b1, p[1:0]));
    $display("test power done");
    wr(w2(3'h1, 10'h005, 1'b1, 3'($urandom), 1'b0, 1'b0, 1'b0));
    wr(w4(3'($urandom), 1'b0, 1'b1, 2'h2));
    wr(w0(16'h0017, 12'($urandom) | 12'h001));
    $display("test buffering done");
    for (int t = 6; t < 8; t++)
      wr({29'($urandom), t[2:0]});
    $display("test unused targets done");
    for (int m = 0; m < 8; m++)
      wr(w2(m[2:0], 10'h001, 1'b0, 3'($urandom), 1'b1, m[0], m[1]));
    wr(w2(3'h6, 10'h001, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0));
    wr(w0(16'h0001, 12'h000));
    $display("test monitor done");
    wr(w4(3'h5, 1'b1, 1'b1, 2'h3));
    pllRun <= 1'b1;
    waitLock(1'b1);
    pllRun <= 1'b0;
    wr(w0(16'h0002, 12'h000));
    pllRun <= 1'b1;
    waitLock(1'b0);
    $display("test lock done");
    conclude();
  end
endmodule // synth_serial_program_latches_test

`default_nettype wire
